// ==== shared/tlp_tx_pkg.sv ====
package tlp_tx_pkg;
	localparam int DESC_W          = 128;
	localparam int DATA_W          = 64;
	localparam int DW_W            = 32;
	localparam int BYTE_W          = 8;
	localparam int HDR_BYTES       = 16;
	localparam int NUM_VC          = 2;
	localparam int GROUP_BIT       = 126;   // packet group / has-data flag
	localparam int GROUP_HI_BIT    = 127;
	localparam int FMT_HI          = 126;
	localparam int FMT_LO          = 125;   // set: four-doubleword header
	localparam int TYPE_HI         = 126;
	localparam int TYPE_LO         = 120;
	localparam int LEN_HI          = 105;
	localparam int LEN_LO          = 96;
	localparam int ALIGN_BIT_4DW   = 2;
	localparam int ALIGN_BIT_3DW   = 34;
	localparam int LEN_W           = 10;
	localparam int ACK_LATENCY     = 1;     // least cycles from request to acknowledge
	localparam logic [LEN_W-1:0] LEN_ONE = 10'h001;

	// alignment bit chosen by header size
	function automatic logic desc_align_high(input logic [DESC_W-1:0] d);
		return d[FMT_LO] ? d[ALIGN_BIT_4DW] : d[ALIGN_BIT_3DW];
	endfunction : desc_align_high

	function automatic logic desc_has_data(input logic [DESC_W-1:0] d);
		return d[GROUP_BIT];
	endfunction : desc_has_data

	function automatic logic desc_is_4dw(input logic [DESC_W-1:0] d);
		return d[FMT_LO];
	endfunction : desc_is_4dw

	// header byte n sits most-significant first
	function automatic logic [BYTE_W-1:0] desc_byte(input logic [DESC_W-1:0] d, input int n);
		return d[DESC_W-1-n*BYTE_W -: BYTE_W];
	endfunction : desc_byte

	function automatic logic [LEN_W-1:0] desc_len(input logic [DESC_W-1:0] d);
		return d[LEN_HI:LEN_LO];
	endfunction : desc_len
endpackage : tlp_tx_pkg

// ==== shared/tlp_tx_if.sv ====
`timescale 1ns/1ps
interface tlp_tx_if;
	import tlp_tx_pkg::*;
	logic              tx_request;
	logic [DESC_W-1:0] tx_descriptor;
	logic              desc_ack;
	logic              data_framing;
	logic              payload_valid;
	logic [DATA_W-1:0] payload_data;
	logic              core_wait_state;

	modport core (
		input  tx_request,
		input  tx_descriptor,
		output desc_ack,
		input  data_framing,
		input  payload_valid,
		input  payload_data,
		output core_wait_state
	);
	modport app (
		output tx_request,
		output tx_descriptor,
		input  desc_ack,
		output data_framing,
		output payload_valid,
		output payload_data,
		input  core_wait_state
	);
endinterface : tlp_tx_if

// ==== core/tlp_tx_core_end.sv ====
`timescale 1ns/1ps
// Behaviour
// - separate descriptor and payload bus per channel
// - descriptor is header; bits 127:126 group
// - payload phases only for data packets
// - no malformed checks, forward as given
// - one full signal set per channel
// - request valid with header same cycle
// - request held until acknowledge
// - back-to-back requests need no gap
// - header byte 0 at bits 127:120
// - three or four doubleword headers accepted
// - alignment bit low: first dword low half
// - alignment bit high: first dword high half
// - bit 126 says packet carries data
// - length, format, type at fixed positions
// - acknowledge lasts exactly one cycle
// - request after acknowledge is fresh request
// - framing with request, held till last-but-one
// - no payload before acknowledge; 3DW may coincide
module tlp_tx_core_end
	import tlp_tx_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	tlp_tx_if.core                 link,                   // one link per virtual channel
	input  wire logic              core_ready,
	input  wire logic              out_ready,
	output logic                   hdr_valid,
	output logic [DESC_W-1:0]      hdr_out,
	output logic [BYTE_W-1:0]      hdr_first_byte,
	output logic                   hdr_has_data,
	output logic                   hdr_is_4dw,
	output logic [LEN_W-1:0]       hdr_length,
	output logic                   dw_valid,
	output logic [DW_W-1:0]        dw_out,
	output logic                   dw_last
);
	typedef enum logic [1:0] {ST_IDLE, ST_ACKED, ST_DATA} core_state_t;

	core_state_t       state_reg;
	logic              ack_reg;
	logic              align_reg;
	logic              first_reg;
	logic              four_dw_reg;
	logic [LEN_W-1:0]  remain_reg;
	logic              take_desc;
	logic              data_allowed;
	logic              beat_take;
	logic              hi_pending_reg;
	logic [DW_W-1:0]   hi_word_reg;
	logic              hi_last_reg;
	logic              take_data;
	logic              beat_high_first;
	logic [LEN_W-1:0]  beat_dws;
	logic              last_beat;
	logic              hi_emit;
	logic              split_beat;

	// doublewords carried by a beat: one when it starts high or only one remains
	function automatic logic [LEN_W-1:0] dw_in_beat(input logic start_high, input logic [LEN_W-1:0] rem);
		return (start_high || rem == LEN_ONE) ? LEN_ONE : LEN_W'(2);
	endfunction : dw_in_beat

	// acknowledge request when no packet is open and sink can take a header
	assign take_desc = link.tx_request && !ack_reg && state_reg == ST_IDLE
		&& core_ready && out_ready;
	assign link.desc_ack = ack_reg;

	// payload is allowed from the acknowledge cycle for 3DW, after it for 4DW
	assign data_allowed = (state_reg == ST_DATA) || (state_reg == ST_ACKED && !four_dw_reg);
	assign link.core_wait_state = !data_allowed || !out_ready || hi_pending_reg;
	assign beat_take = link.payload_valid && !link.core_wait_state;

	// a data packet is opened when its header is taken
	assign take_data = take_desc && desc_has_data(link.tx_descriptor);

	// shape of the beat now on the bus
	assign beat_high_first = first_reg && align_reg;
	assign beat_dws        = dw_in_beat(beat_high_first, remain_reg);
	assign last_beat       = remain_reg <= beat_dws;

	// high half of a two-dword beat is held back until a later cycle with out_ready high
	assign hi_emit    = hi_pending_reg && out_ready;
	assign split_beat = beat_take && !beat_high_first && remain_reg != LEN_ONE;

	// one-cycle acknowledge pulse
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= take_desc;
		end
	end

	// packet state: header taken, then data phases if the group bit says so
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (take_data) begin
						state_reg <= ST_ACKED;
					end
				end
				ST_ACKED, ST_DATA: begin
					if (beat_take && last_beat) begin
						state_reg <= ST_IDLE;
					end else begin
						state_reg <= ST_DATA;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// payload shape latched from the header of a data packet
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			align_reg   <= 1'b0;
			four_dw_reg <= 1'b0;
		end else if (take_data) begin
			align_reg   <= desc_align_high(link.tx_descriptor);
			four_dw_reg <= desc_is_4dw(link.tx_descriptor);
		end
	end

	// doublewords still owed and whether the next beat is the first
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			remain_reg <= '0;
			first_reg  <= 1'b0;
		end else if (take_data) begin
			remain_reg <= desc_len(link.tx_descriptor);
			first_reg  <= 1'b1;
		end else if (beat_take) begin
			remain_reg <= remain_reg - beat_dws;
			first_reg  <= 1'b0;
		end
	end

	// header strobe follows the take by one cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hdr_valid <= 1'b0;
		end else begin
			hdr_valid <= take_desc;
		end
	end

	// header fields handed downstream unchanged, no checks performed
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hdr_out        <= '0;
			hdr_first_byte <= '0;
			hdr_has_data   <= 1'b0;
			hdr_is_4dw     <= 1'b0;
			hdr_length     <= '0;
		end else if (take_desc) begin
			hdr_out        <= link.tx_descriptor;
			hdr_first_byte <= desc_byte(link.tx_descriptor, 0);
			hdr_has_data   <= desc_has_data(link.tx_descriptor);
			hdr_is_4dw     <= desc_is_4dw(link.tx_descriptor);
			hdr_length     <= desc_len(link.tx_descriptor);
		end
	end

	// holding register for the high doubleword of a split beat
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hi_pending_reg <= 1'b0;
			hi_word_reg    <= '0;
			hi_last_reg    <= 1'b0;
		end else if (hi_emit) begin
			hi_pending_reg <= 1'b0;
		end else if (split_beat) begin
			hi_pending_reg <= 1'b1;
			hi_word_reg    <= link.payload_data[DATA_W-1:DW_W];
			hi_last_reg    <= remain_reg == LEN_W'(2);
		end
	end

	// one doubleword a cycle to the sink, honouring first-dword alignment
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dw_valid <= 1'b0;
			dw_out   <= '0;
			dw_last  <= 1'b0;
		end else if (hi_emit) begin
			dw_valid <= 1'b1;
			dw_out   <= hi_word_reg;
			dw_last  <= hi_last_reg;
		end else if (beat_take) begin
			dw_valid <= 1'b1;
			dw_last  <= remain_reg == LEN_ONE;
			if (beat_high_first) begin
				dw_out <= link.payload_data[DATA_W-1:DW_W];
			end else begin
				dw_out <= link.payload_data[DW_W-1:0];
			end
		end else begin
			dw_valid <= 1'b0;
			dw_last  <= 1'b0;
		end
	end
endmodule : tlp_tx_core_end

// ==== core/tlp_tx_app_end.sv ====
`timescale 1ns/1ps
module tlp_tx_app_end
	import tlp_tx_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	tlp_tx_if.app                  link,
	input  wire logic              pkt_valid,
	input  wire logic [DESC_W-1:0] pkt_desc,
	output logic                   pkt_ready,
	input  wire logic              beat_valid,
	input  wire logic [DATA_W-1:0] beat_data,
	output logic                   beat_ready
);
	typedef enum logic [1:0] {A_IDLE, A_REQ, A_DATA} app_state_t;

	app_state_t        state_reg;
	logic [DESC_W-1:0] desc_reg;
	logic              req_reg;
	logic              frame_reg;
	logic              dv_reg;
	logic [DATA_W-1:0] data_reg;
	logic [LEN_W-1:0]  beats_reg;
	logic              load;
	logic              beat_go;

	// new packet accepted when nothing pending or on the acknowledge cycle of a packet without data
	assign load      = pkt_valid && (state_reg == A_IDLE || (state_reg == A_REQ && link.desc_ack
		&& !desc_has_data(desc_reg)));
	assign pkt_ready = load;
	assign beat_go   = state_reg == A_DATA && (!dv_reg || !link.core_wait_state) && beats_reg != '0;
	assign beat_ready = beat_go && beat_valid;

	assign link.tx_request    = req_reg;
	assign link.tx_descriptor = desc_reg;
	assign link.data_framing  = frame_reg;
	assign link.payload_valid = dv_reg;
	assign link.payload_data  = data_reg;

	// number of 64-bit beats a payload needs given alignment and length
	function automatic logic [LEN_W-1:0] beats_for(input logic [DESC_W-1:0] d);
		logic [LEN_W:0] dws;
		dws = {1'b0, desc_len(d)} + {{LEN_W{1'b0}}, desc_align_high(d)};
		return LEN_W'((dws + (LEN_W+1)'(1)) >> 1);
	endfunction : beats_for

	// request and descriptor hold until acknowledge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= A_IDLE;
			req_reg   <= 1'b0;
			desc_reg  <= '0;
			frame_reg <= 1'b0;
			beats_reg <= '0;
		end else begin
			case (state_reg)
				A_IDLE, A_REQ: begin
					if (state_reg == A_REQ && link.desc_ack && desc_has_data(desc_reg)) begin
						state_reg <= A_DATA;
						req_reg   <= 1'b0;
					end else if (state_reg == A_REQ && link.desc_ack && !load) begin
						state_reg <= A_IDLE;
						req_reg   <= 1'b0;
					end
					if (load) begin
						state_reg <= A_REQ;
						req_reg   <= 1'b1;
						desc_reg  <= pkt_desc;
						frame_reg <= desc_has_data(pkt_desc);
						beats_reg <= desc_has_data(pkt_desc) ? beats_for(pkt_desc) : '0;
					end
				end
				A_DATA: begin
					if (beat_ready) begin
						beats_reg <= beats_reg - LEN_W'(1);
						if (beats_reg == LEN_W'(1)) begin            // last beat loaded: framing ends with it
							frame_reg <= 1'b0;
						end
					end
					if (dv_reg && !link.core_wait_state && beats_reg == '0) begin
						state_reg <= A_IDLE;
					end
				end
				default: state_reg <= A_IDLE;
			endcase
		end
	end

	// payload beats, held while the core inserts wait states
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dv_reg   <= 1'b0;
			data_reg <= '0;
		end else begin
			if (beat_ready) begin
				dv_reg   <= 1'b1;
				data_reg <= beat_data;
			end else if (!dv_reg || !link.core_wait_state) begin
				dv_reg <= 1'b0;
			end
		end
	end
endmodule : tlp_tx_app_end

// ==== verification/tlp_tx_chk.sv ====
`timescale 1ns/1ps
// watches the descriptor link between the two ends
module tlp_tx_chk
	import tlp_tx_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              tx_request,
	input wire logic [DESC_W-1:0] tx_descriptor,
	input wire logic              desc_ack,
	input wire logic              data_framing,
	input wire logic              payload_valid,
	input wire logic [DATA_W-1:0] payload_data,
	input wire logic              core_wait_state
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ack never lasts two cycles
	property p_ack_pulse;
		desc_ack |=> !desc_ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	// request stays up until it is acked
	property p_req_hold;
		tx_request && !desc_ack |=> tx_request;
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped before ack");
	// header does not move while pending
	property p_desc_stable;
		tx_request && !desc_ack |=> $stable(tx_descriptor);
	endproperty
	a_desc_stable: assert property (p_desc_stable) else $error("header changed while pending");
	// ack only answers a live request
	property p_ack_has_req;
		desc_ack |-> tx_request && $past(tx_request);
	endproperty
	a_ack_has_req: assert property (p_ack_has_req) else $error("ack without request");
	// a new request is never acked in its own cycle
	property p_ack_latency;
		$rose(tx_request) |-> !desc_ack;
	endproperty
	a_ack_latency: assert property (p_ack_latency) else $error("ack too early");
	// framing only for packets that carry data
	property p_frame_data;
		$rose(data_framing) |-> tx_descriptor[GROUP_BIT];
	endproperty
	a_frame_data: assert property (p_frame_data) else $error("framing on packet without data");
	// framing only rises while the request is up
	property p_frame_req;
		$rose(data_framing) |-> tx_request;
	endproperty
	a_frame_req: assert property (p_frame_req) else $error("framing without request");
	// a stalled beat is held unchanged
	property p_beat_hold;
		payload_valid && core_wait_state |=> payload_valid && $stable(payload_data);
	endproperty
	a_beat_hold: assert property (p_beat_hold) else $error("beat lost during wait");
endmodule : tlp_tx_chk

// ==== verification/tlp_tx_descriptor_phase_bench.sv ====
`timescale 1ns/1ps
// drives the app end, checks what leaves the core end
module tlp_tx_descriptor_phase_bench;
	import tlp_tx_pkg::*;
	logic              clk = 1'h0;
	logic              rst_n = 1'h0;
	logic              core_ready = 1'h1;
	logic              out_ready = 1'h1;
	logic              pkt_valid = 1'h0;
	logic              beat_valid = 1'h0;
	logic [DESC_W-1:0] pkt_desc = '0;
	logic [DATA_W-1:0] beat_data = '0;
	logic              pkt_ready, beat_ready, hdr_valid, hdr_has_data, hdr_is_4dw, dw_valid, dw_last;
	logic [DESC_W-1:0] hdr_out, hd;
	logic [BYTE_W-1:0] hdr_first_byte;
	logic [LEN_W-1:0]  hdr_length;
	logic [DW_W-1:0]   dw_out;
	logic [DW_W:0]     wd;
	logic [DESC_W-1:0] hq[$];
	logic [DW_W:0]     dq[$];
	int                mismatches = 0;
	int                total_checks = 0;
	integer            seed = 32'h0773;

	tlp_tx_if link_if ();
	tlp_tx_app_end tlp_tx_app_end_i (.clk(clk), .rst_n(rst_n), .link(link_if.app), .pkt_valid(pkt_valid),
		.pkt_desc(pkt_desc), .pkt_ready(pkt_ready), .beat_valid(beat_valid), .beat_data(beat_data),
		.beat_ready(beat_ready));
	tlp_tx_core_end tlp_tx_core_end_i (.clk(clk), .rst_n(rst_n), .link(link_if.core), .core_ready(core_ready),
		.out_ready(out_ready), .hdr_valid(hdr_valid), .hdr_out(hdr_out), .hdr_first_byte(hdr_first_byte),
		.hdr_has_data(hdr_has_data), .hdr_is_4dw(hdr_is_4dw), .hdr_length(hdr_length), .dw_valid(dw_valid),
		.dw_out(dw_out), .dw_last(dw_last));
	tlp_tx_chk tlp_tx_chk_i (.clk(clk), .rst_n(rst_n), .tx_request(link_if.tx_request),
		.tx_descriptor(link_if.tx_descriptor), .desc_ack(link_if.desc_ack), .data_framing(link_if.data_framing),
		.payload_valid(link_if.payload_valid), .payload_data(link_if.payload_data),
		.core_wait_state(link_if.core_wait_state));

	always #12.5 clk = ~clk;

	// random stalls on both core-side inputs
	always @(posedge clk) begin
		core_ready <= ($random(seed) & 3) != 0;
		out_ready <= ($random(seed) & 7) != 0;
	end

	task automatic check(input logic [DESC_W-1:0] seen, input logic [DESC_W-1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	// bounded wait for a handshake of the app end
	task automatic wait_ready(input bit beat);
		int n;
		for (n = 0; n < 400; n++) begin
			@(posedge clk);
			if ((beat ? beat_ready : pkt_ready) === 1'h1)
				return;
		end
		mismatches++;
		stop_test();
	endtask : wait_ready

	// one packet: header, then its dwords packed by alignment
	task automatic send(input bit has, input bit four, input bit al, input int len);
		logic [DESC_W-1:0] d;
		logic [DATA_W-1:0] b;
		logic [DW_W-1:0]   w;
		int                k;
		int                pos;
		d = {$random(seed), $random(seed), $random(seed), $random(seed)};
		d[GROUP_BIT] = has;
		d[FMT_LO] = four;
		d[LEN_HI:LEN_LO] = len[LEN_W-1:0];
		if (four)
			d[ALIGN_BIT_4DW] = al;
		else
			d[ALIGN_BIT_3DW] = al;
		hq.push_back(d);
		pkt_valid <= 1'h1;
		pkt_desc <= d;
		wait_ready(1'h0);
		if (!has)
			return;
		pkt_valid <= 1'h0;
		pos = al;
		b = {$random(seed), $random(seed)};
		for (k = 0; k < len; k++) begin
			w = $random(seed);
			b[pos*DW_W +: DW_W] = w;
			dq.push_back({k == len - 1, w});
			pos = 1 - pos;
			if (pos == 0 || k == len - 1) begin
				beat_valid <= 1'h1;
				beat_data <= b;
				wait_ready(1'h1);
				b = {$random(seed), $random(seed)};
			end
		end
		beat_valid <= 1'h0;
	endtask : send

	// compares each output against the oldest note
	always @(posedge clk) begin
		if (rst_n === 1'h1 && hdr_valid === 1'h1) begin
			hd = hq.size() ? hq.pop_front() : 'x;
			check(hdr_out, hd);
			check(hdr_first_byte, hd[127:120]);
			check(hdr_has_data, hd[GROUP_BIT]);
			check(hdr_is_4dw, hd[FMT_LO]);
			check(hdr_length, hd[LEN_HI:LEN_LO]);
		end
		if (rst_n === 1'h1 && dw_valid === 1'h1) begin
			wd = dq.size() ? dq.pop_front() : 'x;
			check({dw_last, dw_out}, wd);
		end
	end

	initial begin
		int i;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		// back-to-back headers without a low request cycle
		send(1'h0, 1'h0, 1'h0, 1);
		send(1'h0, 1'h1, 1'h0, 1);
		send(1'h0, 1'h0, 1'h1, 2);
		// every header size and alignment, odd lengths for 3DW and even lengths for 4DW
		for (i = 0; i < 8; i++)
			send(1'h1, i[0], i[1], i + 1);
		pkt_valid <= 1'h0;
		for (i = 0; i < 400 && (hq.size() || dq.size()); i++)
			@(posedge clk);
		if (hq.size() || dq.size())
			mismatches++;
		stop_test();
	end
endmodule : tlp_tx_descriptor_phase_bench
